// ---- rtl/cal_pkg.sv ----
// Constants for the capability word and linked-load address registers.
// Assumes a coprocessor-0 style move port in the core clock domain.
package cal_pkg;
  // Register numbers and selects on the coprocessor move port
  localparam logic [4:0] CAP_REG_NUM    = 5'h10;
  localparam logic [2:0] CAP_REG_SEL    = 3'h1;
  localparam logic [4:0] LLA_REG_NUM    = 5'h11;
  localparam logic [2:0] LLA_REG_SEL    = 3'h0;
  // Capability word field positions (low bit of each)
  localparam int CAP_MORE_BIT   = 31;
  localparam int CAP_TLB_LO     = 25;
  localparam int CAP_IS_LO      = 22;
  localparam int CAP_IL_LO      = 19;
  localparam int CAP_IA_LO      = 16;
  localparam int CAP_DS_LO      = 13;
  localparam int CAP_DL_LO      = 10;
  localparam int CAP_DA_LO      = 7;
  localparam int CAP_PERF_BIT   = 4;
  localparam int CAP_WATCH_BIT  = 3;
  localparam int CAP_COMP_BIT   = 2;
  localparam int CAP_DEBUG_BIT  = 1;
  localparam int CAP_FLOAT_BIT  = 0;
  // Fixed values of the capability word
  localparam logic [5:0] TLB_ENTRIES_M1 = 6'h0F;
  localparam logic [5:0] FIXED_MAP_M1   = 6'h00;
  localparam logic [2:0] LINE_NONE      = 3'h0;
  localparam logic [2:0] LINE_16B       = 3'h3;
  localparam logic [2:0] SETS_MAX_CODE  = 3'h2;
  localparam logic [2:0] ASSOC_MAX_CODE = 3'h3;
  localparam logic       MORE_WORDS     = 1'h0;
  localparam logic       PERF_PRESENT   = 1'h0;
  localparam logic       WATCH_PRESENT  = 1'h1;
  localparam logic       COMP_PRESENT   = 1'h0;
  localparam logic       DEBUG_PRESENT  = 1'h1;
  localparam logic       FLOAT_PRESENT  = 1'h0;
  // Linked-load address layout
  localparam int LLA_ADDR_W   = 28;
  localparam int LLA_PADDR_LO = 4;
  localparam logic [3:0] LLA_TOP_ZERO = 4'h0;
endpackage

// ---- rtl/cal_lla_if.sv ----
// Interface carrying linked-load capture between core and its store.
// Assumes both ends run on sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface cal_lla_if;
  logic        load_linked_access; // Capture strobe
  logic [27:0] paddr_hi;           // Physical address bits 31:4
  logic [27:0] held;               // Stored address field
  modport core (output load_linked_access, output paddr_hi, input held);
  modport store (input load_linked_access, input paddr_hi, output held);
endinterface
`default_nettype wire

// ---- rtl/cal_lla_store.sv ----
// Holder for the address of the most recent load-linked access.
// Assumes capture strobe and address come from sys_clk logic.
`timescale 1ns/100ps
`default_nettype none
module cal_lla_store (
  input  wire logic sys_clk, // Core clock
  cal_lla_if.store  lla      // Capture carrier
);
  logic [27:0] addr;
  logic [27:0] next_addr;

  // Load the new address on each load-linked access
  always_comb begin
    next_addr = addr;
    if (lla.load_linked_access) begin
      next_addr = lla.paddr_hi;
    end
  end

  // No reset: the field is undefined until the first capture
  always_ff @(posedge sys_clk) begin
    addr <= next_addr;
  end

  assign lla.held = addr;

  a_lla_capture: assert property (@(posedge sys_clk)
    lla.load_linked_access |=> addr == $past(lla.paddr_hi))
    else $error("linked address not captured");
endmodule // cal_lla_store
`default_nettype wire

// ---- rtl/cal_cap_regs.sv ----
// Capability word one and linked-load address register bank.
// Assumes the core issues coprocessor register moves on sys_clk and
// reports each load-linked access with its physical address.
// Functional notes
// - Capability top bit reads zero: no further capability word.
// - Bits 30:25 give TLB entries minus one: 15 TLB, 0 fixed map.
// - Bits 24:22 encode icache sets 64/128/256 as 0..2.
// - Bits 21:19 read 0 without icache, 3 for 16-byte lines.
// - Bits 18:16 encode icache ways 1..4 as 0..3.
// - Bits 15:13 encode dcache sets 64/128/256 as 0..2.
// - Bits 12:10 read 0 without dcache, 3 for 16-byte lines.
// - Bits 9:7 encode dcache ways 1..4 as 0..3.
// - Bits 6:5 read zero; software writes zeros.
// - Bit 4 reads zero: no performance counters.
// - Bit 3 reads one: one watch register pair.
// - Bit 2 reads zero: no code compression.
// - Bit 1 reads one: debug unit present.
// - Bit 0 reads zero: no floating-point unit.
// - Geometry fields describe the real caches; zero line means absent.
// - Linked address captures PAddr 31:4 of last load-linked access.
// - Linked address is diagnostic only, no effect on operation.
// - Linked address read-only, bits 31:28 zero, field undefined at reset.
`timescale 1ns/100ps
`default_nettype none
module cal_cap_regs #(
  parameter bit          HAS_TLB     = 1'b1, // TLB build versus fixed mapping
  parameter int unsigned ICACHE_SETS = 256,  // Icache sets per way
  parameter int unsigned ICACHE_WAYS = 4,    // Icache ways, 0 = no icache
  parameter int unsigned DCACHE_SETS = 256,  // Dcache sets per way
  parameter int unsigned DCACHE_WAYS = 4     // Dcache ways, 0 = no dcache
) (
  input  wire logic        sys_clk,            // Core clock, 200 MHz
  input  wire logic        rst_n,              // Asynchronous reset, active low
  input  wire logic        cp_rd_en,           // Register move-from request
  input  wire logic        cp_wr_en,           // Register move-to request
  input  wire logic [4:0]  cp_reg_num,         // Register number
  input  wire logic [2:0]  cp_reg_sel,         // Register select
  input  wire logic [31:0] cp_wr_data,         // Move-to data (ignored)
  output var  logic [31:0] cp_rd_data,         // Move-from data, registered
  output var  logic        cp_rd_hit,          // Read matched a register here
  input  wire logic        load_linked_access, // Load-linked access strobe
  input  wire logic [31:0] ll_paddr            // Physical address of the access
);

  // Reject geometry the encodings cannot express
  if (!(ICACHE_SETS inside {64, 128, 256})) begin : g_bad_isets
    $error("icache sets per way must be 64, 128 or 256");
  end
  if (!(DCACHE_SETS inside {64, 128, 256})) begin : g_bad_dsets
    $error("dcache sets per way must be 64, 128 or 256");
  end
  if (ICACHE_WAYS > 4) begin : g_bad_iways
    $error("icache associativity must be 0 to 4");
  end
  if (DCACHE_WAYS > 4) begin : g_bad_dways
    $error("dcache associativity must be 0 to 4");
  end

  // Sets-per-way code for a set count
  function automatic logic [2:0] sets_code(input int unsigned sets);
    logic [2:0] c;
    c = 3'h0;
    if (sets == 128) c = 3'h1;
    else if (sets == 256) c = 3'h2;
    return c;
  endfunction

  // Associativity code for a way count
  function automatic logic [2:0] ways_code(input int unsigned ways);
    logic [2:0] c;
    c = 3'h0;
    if (ways > 1) c = 3'(ways - 1);
    return c;
  endfunction

  // Capability word assembled from fixed flags and build geometry
  localparam logic [2:0] IS_CODE = sets_code(ICACHE_SETS);
  localparam logic [2:0] DS_CODE = sets_code(DCACHE_SETS);
  localparam logic [2:0] IA_CODE = ways_code(ICACHE_WAYS);
  localparam logic [2:0] DA_CODE = ways_code(DCACHE_WAYS);
  localparam logic [2:0] IL_CODE = (ICACHE_WAYS == 0) ? cal_pkg::LINE_NONE
                                                      : cal_pkg::LINE_16B;
  localparam logic [2:0] DL_CODE = (DCACHE_WAYS == 0) ? cal_pkg::LINE_NONE
                                                      : cal_pkg::LINE_16B;
  localparam logic [5:0] TLB_CODE = HAS_TLB ? cal_pkg::TLB_ENTRIES_M1
                                            : cal_pkg::FIXED_MAP_M1;
  localparam logic [31:0] CAP_WORD = {
    cal_pkg::MORE_WORDS,
    TLB_CODE,
    IS_CODE, IL_CODE, IA_CODE,
    DS_CODE, DL_CODE, DA_CODE,
    2'h0,
    cal_pkg::PERF_PRESENT,
    cal_pkg::WATCH_PRESENT,
    cal_pkg::COMP_PRESENT,
    cal_pkg::DEBUG_PRESENT,
    cal_pkg::FLOAT_PRESENT
  };

  // Address-decode helper
  function automatic logic reg_match(input logic [4:0] n, input logic [2:0] s,
                                     input logic [4:0] rn, input logic [2:0] rs);
    return (n == rn) && (s == rs);
  endfunction

  cal_lla_if lla ();

  // Capture path feeds the store; elsewhere only the checks read it
  assign lla.load_linked_access = load_linked_access;
  assign lla.paddr_hi = ll_paddr[31:cal_pkg::LLA_PADDR_LO];

  cal_lla_store u_store (
    .sys_clk (sys_clk),
    .lla     (lla)
  );

  logic        sel_cap;
  logic        sel_lla;
  logic [31:0] next_rd_data;
  logic        next_rd_hit;

  assign sel_cap = reg_match(cp_reg_num, cp_reg_sel, cal_pkg::CAP_REG_NUM,
                             cal_pkg::CAP_REG_SEL);
  assign sel_lla = reg_match(cp_reg_num, cp_reg_sel, cal_pkg::LLA_REG_NUM,
                             cal_pkg::LLA_REG_SEL);

  // Read mux; writes are deliberately not decoded
  always_comb begin
    next_rd_data = 32'h0000_0000;
    next_rd_hit  = 1'b0;
    if (cp_rd_en && sel_cap) begin
      next_rd_data = CAP_WORD;
      next_rd_hit  = 1'b1;
    end else if (cp_rd_en && sel_lla) begin
      next_rd_data = {cal_pkg::LLA_TOP_ZERO, lla.held};
      next_rd_hit  = 1'b1;
    end
  end

  // Read data register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_rd_data <= 32'h0000_0000;
      cp_rd_hit  <= 1'b0;
    end else begin
      cp_rd_data <= next_rd_data;
      cp_rd_hit  <= next_rd_hit;
    end
  end

  // Checks only: marks that the held address has been loaded since reset.
  // The store has no reset, so its field stays unknown until a capture,
  // and the hold check must not look at it before then.
  logic seen_capture;
  logic next_seen_capture;

  // Set on the first capture, cleared only by reset
  always_comb begin
    next_seen_capture = seen_capture;
    if (load_linked_access) begin
      next_seen_capture = 1'b1;
    end
  end

  // Capture-seen flag register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_capture <= 1'b0;
    end else begin
      seen_capture <= next_seen_capture;
    end
  end

  // Bytes held by a cache whose fields read back as given; zero if absent
  function automatic int unsigned decoded_bytes(input logic [2:0] sets_f,
                                                input logic [2:0] line_f,
                                                input logic [2:0] ways_f);
    int unsigned bytes;
    bytes = 32'd0;
    if (line_f == cal_pkg::LINE_16B) begin
      bytes = (32'(ways_f) + 32'd1) * 32'd16 * (32'd64 << sets_f);
    end
    return bytes;
  endfunction

  // Real cache sizes of this build; zero ways gives zero bytes
  localparam int unsigned ICACHE_BYTES = ICACHE_WAYS * 32'd16 * ICACHE_SETS;
  localparam int unsigned DCACHE_BYTES = DCACHE_WAYS * 32'd16 * DCACHE_SETS;

  // Capability word, linked address and write checks on each request
  a_cap_word_fixed: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_hit && cp_rd_data == CAP_WORD)
    else $error("capability word read wrong");
  a_cap_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[6:0] == 7'h0A)
    else $error("capability flags wrong");
  a_cap_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> !cp_rd_data[31])
    else $error("capability top bit set");
  a_cap_line_geom: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> (cp_rd_data[21:19] inside {3'h0, 3'h3})
                         && (cp_rd_data[12:10] inside {3'h0, 3'h3}))
    else $error("line size code reserved");
  a_cap_tlb_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[30:25] == (HAS_TLB ? 6'h0F : 6'h00))
    else $error("tlb size field wrong");
  a_lla_top_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_lla |=> cp_rd_hit && cp_rd_data[31:28] == 4'h0)
    else $error("linked address top bits set");
  a_lla_read_back: assert property (@(posedge sys_clk) disable iff (!rst_n)
    load_linked_access ##1 (cp_rd_en && sel_lla && !load_linked_access)
      |=> cp_rd_data[27:0] == $past(lla.paddr_hi, 2))
    else $error("linked address read back wrong");
  a_write_inert: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_wr_en && !cp_rd_en |=> !cp_rd_hit && cp_rd_data == 32'h0000_0000)
    else $error("write produced read data");

  // Icache sets code stays in the defined range
  a_icache_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[24:22] <= cal_pkg::SETS_MAX_CODE)
    else $error("icache sets code reserved");

  // Icache line code follows presence of the icache
  a_icache_line: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[21:19] == ((ICACHE_WAYS == 0) ? 3'h0 : 3'h3))
    else $error("icache line code wrong");

  // Icache ways code stays in the defined range
  a_icache_ways: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[18:16] <= cal_pkg::ASSOC_MAX_CODE)
    else $error("icache ways code reserved");

  // Dcache sets code stays in the defined range
  a_dcache_sets: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[15:13] <= cal_pkg::SETS_MAX_CODE)
    else $error("dcache sets code reserved");

  // Dcache line code follows presence of the dcache
  a_dcache_line: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[12:10] == ((DCACHE_WAYS == 0) ? 3'h0 : 3'h3))
    else $error("dcache line code wrong");

  // Dcache ways code stays in the defined range
  a_dcache_ways: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[9:7] <= cal_pkg::ASSOC_MAX_CODE)
    else $error("dcache ways code reserved");

  // Spare bits read as zero
  a_cap_spare_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[6:5] == 2'h0)
    else $error("capability spare bits set");

  // No performance counters reported
  a_cap_no_perf: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> !cp_rd_data[4])
    else $error("performance counter flag set");

  // No code compression reported
  a_cap_no_comp: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> !cp_rd_data[2])
    else $error("code compression flag set");

  // Debug unit reported present
  a_cap_debug_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> cp_rd_data[1])
    else $error("debug unit flag clear");

  // No floating-point unit reported
  a_cap_no_float: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> !cp_rd_data[0])
    else $error("floating-point flag set");

  // Icache fields multiply out to the real icache size
  a_icache_capacity: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> decoded_bytes(cp_rd_data[24:22], cp_rd_data[21:19],
                                          cp_rd_data[18:16]) == ICACHE_BYTES)
    else $error("icache geometry does not match size");

  // Dcache fields multiply out to the real dcache size
  a_dcache_capacity: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && sel_cap |=> decoded_bytes(cp_rd_data[15:13], cp_rd_data[12:10],
                                          cp_rd_data[9:7]) == DCACHE_BYTES)
    else $error("dcache geometry does not match size");

  // Idle cycles leave the read port quiet
  a_rd_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cp_rd_en |=> !cp_rd_hit && cp_rd_data == 32'h0000_0000)
    else $error("read data without a read");

  // Unmapped places answer nothing
  a_rd_unmapped: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cp_rd_en && !sel_cap && !sel_lla |=> !cp_rd_hit && cp_rd_data == 32'h0000_0000)
    else $error("unmapped read answered");

  // Held address only moves on a capture
  a_lla_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seen_capture && !load_linked_access |=> lla.held == $past(lla.held))
    else $error("linked address changed without access");

endmodule // cal_cap_regs
`default_nettype wire

// ---- bench/test_capability_and_linked_addr_regs.sv ----
// Self-checking bench for the capability word and linked-load address bank.
// Assumes reads answer one cycle after the request and writes are ignored.
`timescale 1ns/100ps
`default_nettype none
module test_capability_and_linked_addr_regs;
  logic        sys_clk;            // Core clock
  logic        rst_n;              // Reset, active low
  logic        cp_rd_en;           // Read request
  logic        cp_wr_en;           // Write request
  logic [4:0]  cp_reg_num;         // Register number
  logic [2:0]  cp_reg_sel;         // Register select
  logic [31:0] cp_wr_data;         // Write data
  logic [31:0] cp_rd_data;         // Read data
  logic        cp_rd_hit;          // Read matched
  logic        load_linked_access; // Capture strobe
  logic [31:0] ll_paddr;           // Captured address
  int          miscompares;        // Mismatch count
  int          checks_done;        // Comparison count
  logic [31:0] lfsr_state;         // Random source
  logic [31:0] r;                  // Current random draw
  logic [27:0] lla_exp;            // Model of the held address

  cal_cap_regs dut (.sys_clk(sys_clk), .rst_n(rst_n), .cp_rd_en(cp_rd_en),
    .cp_wr_en(cp_wr_en), .cp_reg_num(cp_reg_num), .cp_reg_sel(cp_reg_sel),
    .cp_wr_data(cp_wr_data), .cp_rd_data(cp_rd_data), .cp_rd_hit(cp_rd_hit),
    .load_linked_access(load_linked_access), .ll_paddr(ll_paddr));

  // Clock, 5 ns period
  always #2.5 sys_clk = ~sys_clk;

  // Galois shift register step
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // Capability word of the default build: TLB, 256 sets, 4 ways, 16-byte lines
  function automatic logic [31:0] cap_expected();
    return {1'b0, 6'h0F, 3'h2, 3'h3, 3'h3, 3'h2, 3'h3, 3'h3, 2'h0,
            1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  endfunction

  // Word comparison
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Flag comparison
  task automatic cmp_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One cycle of requests, then check the registered answer
  task automatic step(input logic rd, input logic wr, input logic [4:0] num,
                      input logic [2:0] sel, input logic ll, input logic [31:0] pa);
    logic        hit_exp;
    logic [31:0] data_exp;
    cp_rd_en = rd;
    cp_wr_en = wr;
    cp_reg_num = num;
    cp_reg_sel = sel;
    cp_wr_data = ~pa;
    load_linked_access = ll;
    ll_paddr = pa;
    hit_exp = rd && ((num == 5'h10 && sel == 3'h1) || (num == 5'h11 && sel == 3'h0));
    data_exp = !hit_exp ? 32'h00000000 : (num == 5'h10) ? cap_expected() : {4'h0, lla_exp};
    @(posedge sys_clk);
    #1;
    cmp_bit(cp_rd_hit, hit_exp);
    cmp_word(cp_rd_data, data_exp);
    if (ll) lla_exp = pa[31:4];
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    miscompares = 0;
    checks_done = 0;
    lfsr_state = 32'h27E6A214;
    lla_exp = 28'h0000000;
    step(1'b0, 1'b0, 5'h00, 3'h0, 1'b0, 32'h00000000);
    repeat (4) @(posedge sys_clk);
    #1;
    cmp_bit(cp_rd_hit, 1'b0);
    rst_n = 1'b1;
    // Back-to-back captures, last one wins
    step(1'b0, 1'b0, 5'h00, 3'h0, 1'b1, 32'hFFFFFFFF);
    step(1'b0, 1'b0, 5'h00, 3'h0, 1'b1, 32'h0000000F);
    step(1'b1, 1'b0, 5'h11, 3'h0, 1'b0, 32'h00000000);
    // Capture and read in one cycle returns the older value
    step(1'b1, 1'b0, 5'h11, 3'h0, 1'b1, 32'hA5A55A5F);
    step(1'b1, 1'b1, 5'h11, 3'h0, 1'b0, 32'hFFFFFFFF);
    step(1'b1, 1'b1, 5'h10, 3'h1, 1'b0, 32'hFFFFFFFF);
    // Every number and select, reads with writes alongside
    for (int i = 0; i < 256; i++) begin
      lfsr_state = next_rand(lfsr_state);
      step(1'b1, lfsr_state[0], i[7:3], i[2:0], 1'b0, lfsr_state);
    end
    // Random traffic mixing captures, reads, writes and unmapped places
    for (int i = 0; i < 3000; i++) begin
      lfsr_state = next_rand(lfsr_state);
      r = lfsr_state;
      lfsr_state = next_rand(lfsr_state);
      step(r[0], r[1], r[2] ? (r[3] ? 5'h10 : 5'h11) : r[8:4],
           r[2] ? (r[3] ? 3'h1 : 3'h0) : r[11:9], r[12], lfsr_state);
    end
    summarize();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    summarize();
  end
endmodule // test_capability_and_linked_addr_regs
`default_nettype wire
